/* core/i2cb_mode_addr_cfg.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "i2cb_regs.svh"
// Overview of operation
// - Slave-disable bit, reset 1, turns slave off.
// - Repeated-start permit bit, reset 1, gates RESTARTs.
// - Master width bit picks 7/10-bit master addressing.
// - Slave width bit picks 7/10-bit slave matching.
// - Speed field bits 2:1, 1 standard, 2 fast.
// - Master-enable bit, reset 1, gates master function.
// - Special bit uses the general-call/start-byte selector.
// - Selector 0 general call, 1 start byte.
// - Read after general call sets transmit abort.
// - General call mode holds until special clears; the code also ends it when the selector is set to 1.
// - Target address resets 0x55, ignored for general call.
// - Outside general-call and start-byte modes, master never transmits to its own slave address while the slave is enabled.
// - Target writes only while controller is off.
// - Own address resets 0x55, 7-bit compares bits 6:0.
// - Own address writes only while controller is off.
// - Forbidden restart becomes STOP then START.
module i2cb_mode_addr_cfg #(
	parameter int ADDR_W = 12
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire i2cb_pkg::i2cb_cmd_t cmdIn,
	output logic cmdAccepted_r,
	output logic cmdAborted_r,
	output logic issueRestart_r,
	output logic issueStopStart_r,
	output logic issueGeneralCall_r,
	output logic issueStartByte_r,
	output logic cmdAddrWide_r,
	output logic [9:0] cmdTargetAddr_r,
	output i2cb_pkg::i2cb_ctrl_t cfgCtrl_r,
	output i2cb_pkg::i2cb_target_t cfgTarget_r,
	output logic [9:0] ownAddr_r,
	output logic controllerOn_r,
	output logic abortFlag_r,
	output logic [15:0] sclHalfCount_r,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic slaveMatch_r,
	output logic slaveMatchRead_r
);
	localparam logic [ADDR_W-1:0] ADDR_PARAM_HIGH = ADDR_W'((`I2CB_IDX_PARAM_HIGH - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_VERSION_LOW = ADDR_W'((`I2CB_IDX_VERSION_LOW - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_VERSION_HIGH = ADDR_W'((`I2CB_IDX_VERSION_HIGH - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_TYPE_LOW = ADDR_W'((`I2CB_IDX_TYPE_LOW - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_TYPE_HIGH = ADDR_W'((`I2CB_IDX_TYPE_HIGH - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'((`I2CB_IDX_CONTROL - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_TARGET = ADDR_W'((`I2CB_IDX_TARGET - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_OWN_ADDR = ADDR_W'((`I2CB_IDX_OWN_ADDR - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_ENABLE = ADDR_W'((`I2CB_IDX_ENABLE - `I2CB_IDX_BASE) * 4);
	localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'((`I2CB_IDX_STATUS - `I2CB_IDX_BASE) * 4);
	localparam logic [15:0] HALF_STD = 16'((`I2CB_STD_BIT_NS / 2) / `I2CB_SYS_CLK_NS);
	localparam logic [15:0] HALF_FAST = 16'((`I2CB_FAST_BIT_NS / 2) / `I2CB_SYS_CLK_NS);
	logic awReady_r, wReady_r, awHeld_r, wHeld_r, bValid_r, arReady_r, rValid_r;
	logic [ADDR_W-1:0] awAddr_r;
	logic [31:0] wData_r, rData_r;
	logic [3:0] wStrb_r;
	logic [1:0] bResp_r, rResp_r;
	logic doWrite, wrControl, wrTarget, wrOwnAddr, wrEnable, wrStatus;
	logic [15:0] wrWord, oldWord;
	logic [31:0] readWord;
	logic readHit, writeHit, writeRo;
	assign s_axi_awready = awReady_r;
	assign s_axi_wready = wReady_r;
	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;
	assign s_axi_arready = arReady_r;
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;
	// A write completes once address and data are both held and no response is pending.
	assign doWrite = awHeld_r && wHeld_r && !bValid_r;
	assign wrControl = doWrite && awAddr_r == ADDR_CONTROL;
	assign wrTarget = doWrite && awAddr_r == ADDR_TARGET;
	assign wrOwnAddr = doWrite && awAddr_r == ADDR_OWN_ADDR;
	assign wrEnable = doWrite && awAddr_r == ADDR_ENABLE;
	assign wrStatus = doWrite && awAddr_r == ADDR_STATUS;
	assign writeRo = awAddr_r == ADDR_PARAM_HIGH || awAddr_r == ADDR_VERSION_LOW ||
		awAddr_r == ADDR_VERSION_HIGH || awAddr_r == ADDR_TYPE_LOW || awAddr_r == ADDR_TYPE_HIGH;
	assign writeHit = writeRo || awAddr_r == ADDR_CONTROL || awAddr_r == ADDR_TARGET ||
		awAddr_r == ADDR_OWN_ADDR || awAddr_r == ADDR_ENABLE || awAddr_r == ADDR_STATUS;
	// Bytes without a strobe keep the value the register already holds.
	always_comb begin
		case (awAddr_r)
			ADDR_CONTROL: oldWord = 16'(cfgCtrl_r);
			ADDR_TARGET: oldWord = 16'(cfgTarget_r);
			ADDR_OWN_ADDR: oldWord = 16'(ownAddr_r);
			default: oldWord = 16'h0000;
		endcase
		wrWord = {wStrb_r[1] ? wData_r[15:8] : oldWord[15:8], wStrb_r[0] ? wData_r[7:0] : oldWord[7:0]};
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			awReady_r <= 1'b0;
			awHeld_r <= 1'b0;
			awAddr_r <= '0;
		end else if (s_axi_awvalid && awReady_r) begin
			awHeld_r <= 1'b1;
			awAddr_r <= s_axi_awaddr;
			awReady_r <= 1'b0;
		end else if (doWrite) begin
			awHeld_r <= 1'b0;
			awReady_r <= 1'b1;
		end else if (!awHeld_r) begin
			awReady_r <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wReady_r <= 1'b0;
			wHeld_r <= 1'b0;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
		end else if (s_axi_wvalid && wReady_r) begin
			wHeld_r <= 1'b1;
			wData_r <= s_axi_wdata;
			wStrb_r <= s_axi_wstrb;
			wReady_r <= 1'b0;
		end else if (doWrite) begin
			wHeld_r <= 1'b0;
			wReady_r <= 1'b1;
		end else if (!wHeld_r) begin
			wReady_r <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bValid_r <= 1'b0;
			bResp_r <= `I2CB_RESP_OKAY;
		end else if (doWrite) begin
			bValid_r <= 1'b1;
			bResp_r <= writeHit ? `I2CB_RESP_OKAY : `I2CB_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_r <= 1'b0;
		end
	end
	always_comb begin
		readWord = 32'h00000000;
		readHit = 1'b1;
		case (s_axi_araddr)
			ADDR_PARAM_HIGH, ADDR_VERSION_LOW, ADDR_VERSION_HIGH, ADDR_TYPE_LOW, ADDR_TYPE_HIGH:
				readWord = 32'h00000000;
			ADDR_CONTROL: readWord = 32'(cfgCtrl_r);
			ADDR_TARGET: readWord = 32'(cfgTarget_r);
			ADDR_OWN_ADDR: readWord = 32'(ownAddr_r);
			ADDR_ENABLE: readWord = 32'(controllerOn_r);
			ADDR_STATUS: begin
				readWord[`I2CB_EN_BIT] = controllerOn_r;
				readWord[`I2CB_STAT_ABORT_BIT] = abortFlag_r;
				readWord[`I2CB_STAT_GCMODE_BIT] = cfgTarget_r.special && !cfgTarget_r.gcSel;
				readWord[`I2CB_STAT_MATCH_BIT] = slaveMatch_r;
			end
			default: readHit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			arReady_r <= 1'b0;
			rValid_r <= 1'b0;
			rData_r <= 32'h00000000;
			rResp_r <= `I2CB_RESP_OKAY;
		end else if (s_axi_arvalid && arReady_r) begin
			arReady_r <= 1'b0;
			rValid_r <= 1'b1;
			rData_r <= readWord;
			rResp_r <= readHit ? `I2CB_RESP_OKAY : `I2CB_RESP_SLVERR;
		end else if (rValid_r && s_axi_rready) begin
			rValid_r <= 1'b0;
			arReady_r <= 1'b1;
		end else if (!rValid_r) begin
			arReady_r <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfgCtrl_r <= `I2CB_CTRL_RESET;
		end else if (wrControl) begin
			cfgCtrl_r <= wrWord[`I2CB_CTRL_MSB:0];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfgTarget_r <= `I2CB_TARGET_RESET;
		end else if (wrTarget && !controllerOn_r) begin
			cfgTarget_r <= wrWord[`I2CB_TARGET_MSB:0];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ownAddr_r <= `I2CB_OWN_ADDR_RESET;
		end else if (wrOwnAddr && !controllerOn_r) begin
			ownAddr_r <= wrWord[`I2CB_ADDR_MSB:0];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			controllerOn_r <= 1'b0;
		end else if (wrEnable && wStrb_r[0]) begin
			controllerOn_r <= wData_r[`I2CB_EN_BIT];
		end
	end
	// Unknown speed codes keep the last valid rate.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sclHalfCount_r <= HALF_FAST;
		end else if (cfgCtrl_r.speed == `I2CB_SPEED_STD) begin
			sclHalfCount_r <= HALF_STD;
		end else if (cfgCtrl_r.speed == `I2CB_SPEED_FAST) begin
			sclHalfCount_r <= HALF_FAST;
		end
	end
	logic cmdRefused, gcMode, gcRead, targetHitsOwn, selfTx, abortEvt, acceptEvt, needRestart;
	logic inTransfer_r, lastRead_r;
	assign gcMode = cfgTarget_r.special && !cfgTarget_r.gcSel;
	assign cmdRefused = !controllerOn_r || !cfgCtrl_r.masterOn;
	assign gcRead = gcMode && cmdIn.read;
	assign targetHitsOwn = cfgCtrl_r.masterWide ? cfgTarget_r.addr == ownAddr_r :
		cfgTarget_r.addr[`I2CB_ADDR7_MSB:0] == ownAddr_r[`I2CB_ADDR7_MSB:0];
	assign selfTx = !cmdIn.read && !cfgTarget_r.special && !cfgCtrl_r.slaveOff && targetHitsOwn;
	assign abortEvt = cmdIn.valid && !cmdRefused && (gcRead || selfTx);
	assign acceptEvt = cmdIn.valid && !cmdRefused && !abortEvt;
	assign needRestart = cmdIn.restart || (inTransfer_r && cmdIn.read != lastRead_r);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cmdAccepted_r <= 1'b0;
			cmdAborted_r <= 1'b0;
		end else begin
			cmdAccepted_r <= acceptEvt;
			cmdAborted_r <= cmdIn.valid && !acceptEvt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			issueRestart_r <= 1'b0;
			issueStopStart_r <= 1'b0;
			issueGeneralCall_r <= 1'b0;
			issueStartByte_r <= 1'b0;
			cmdAddrWide_r <= 1'b0;
			cmdTargetAddr_r <= 10'h000;
		end else if (acceptEvt) begin
			issueRestart_r <= needRestart && cfgCtrl_r.restartPermit;
			issueStopStart_r <= needRestart && !cfgCtrl_r.restartPermit;
			issueGeneralCall_r <= gcMode;
			issueStartByte_r <= cfgTarget_r.special && cfgTarget_r.gcSel;
			cmdAddrWide_r <= cfgCtrl_r.masterWide;
			cmdTargetAddr_r <= gcMode ? 10'h000 : cfgTarget_r.addr;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			inTransfer_r <= 1'b0;
			lastRead_r <= 1'b0;
		end else if (acceptEvt) begin
			inTransfer_r <= !cmdIn.stop;
			lastRead_r <= cmdIn.read;
		end else if (!controllerOn_r) begin
			inTransfer_r <= 1'b0;
		end
	end
	// Writing one to the abort bit clears it; a new abort in the same cycle wins.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			abortFlag_r <= 1'b0;
		end else if (abortEvt) begin
			abortFlag_r <= 1'b1;
		end else if (wrStatus && wStrb_r[0] && wData_r[`I2CB_STAT_ABORT_BIT]) begin
			abortFlag_r <= 1'b0;
		end
	end
	logic sclSync1_r, sclSync2_r, sclPrev_r, sdaSync1_r, sdaSync2_r, sdaPrev_r;
	logic sclRise, startCond, stopCond, slaveActive;
	logic [7:0] shift_r, byteNow;
	logic [3:0] bitCnt_r;
	i2cb_pkg::i2cb_snoop_t snoop_r;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sclSync1_r <= 1'b1;
			sclSync2_r <= 1'b1;
			sclPrev_r <= 1'b1;
			sdaSync1_r <= 1'b1;
			sdaSync2_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end else begin
			sclSync1_r <= sclIn;
			sclSync2_r <= sclSync1_r;
			sclPrev_r <= sclSync2_r;
			sdaSync1_r <= sdaIn;
			sdaSync2_r <= sdaSync1_r;
			sdaPrev_r <= sdaSync2_r;
		end
	end

	assign sclRise = sclSync2_r && !sclPrev_r;
	assign startCond = sclSync2_r && sclPrev_r && sdaPrev_r && !sdaSync2_r;
	assign stopCond = sclSync2_r && sclPrev_r && !sdaPrev_r && sdaSync2_r;
	assign slaveActive = controllerOn_r && !cfgCtrl_r.slaveOff;
	assign byteNow = {shift_r[6:0], sdaSync2_r};
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			snoop_r <= i2cb_pkg::I2CB_SNOOP_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			slaveMatch_r <= 1'b0;
			slaveMatchRead_r <= 1'b0;
		end else if (startCond) begin
			snoop_r <= slaveActive ? i2cb_pkg::I2CB_SNOOP_FIRST : i2cb_pkg::I2CB_SNOOP_IDLE;
			bitCnt_r <= 4'h0;
			slaveMatch_r <= 1'b0;
		end else if (stopCond || !slaveActive) begin
			snoop_r <= i2cb_pkg::I2CB_SNOOP_IDLE;
			slaveMatch_r <= 1'b0;
		end else if (sclRise) begin
			if (bitCnt_r == `I2CB_ACK_BIT) begin
				bitCnt_r <= 4'h0;
			end else begin
				bitCnt_r <= bitCnt_r + 4'h1;
				shift_r <= byteNow;
			end
			if (bitCnt_r == `I2CB_BYTE_LAST_BIT) begin
				case (snoop_r)
					i2cb_pkg::I2CB_SNOOP_FIRST: begin
						slaveMatchRead_r <= byteNow[0];
						if (!cfgCtrl_r.slaveWide) begin
							slaveMatch_r <= byteNow[7:1] == ownAddr_r[`I2CB_ADDR7_MSB:0];
							snoop_r <= i2cb_pkg::I2CB_SNOOP_DONE;
						end else if (byteNow[7:3] == `I2CB_WIDE_PREFIX && byteNow[2:1] == ownAddr_r[9:8]) begin
							snoop_r <= i2cb_pkg::I2CB_SNOOP_SECOND;
						end else begin
							snoop_r <= i2cb_pkg::I2CB_SNOOP_DONE;
						end
					end
					i2cb_pkg::I2CB_SNOOP_SECOND: begin
						slaveMatch_r <= byteNow == ownAddr_r[7:0];
						snoop_r <= i2cb_pkg::I2CB_SNOOP_DONE;
					end
					default: snoop_r <= snoop_r;
				endcase
			end
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_ctrl_reset_value: assert property ($past(sys_rst) |-> cfgCtrl_r.slaveOff && cfgCtrl_r.masterOn)
		else $error("Control register left reset with slave or master in the wrong state.");
	chk_restart_gated: assert property ($rose(issueRestart_r) |-> $past(cfgCtrl_r.restartPermit))
		else $error("Restart issued while repeated starts were forbidden.");
	chk_stop_start_swap: assert property (acceptEvt && needRestart && !cfgCtrl_r.restartPermit
		|=> issueStopStart_r && !issueRestart_r)
		else $error("Forbidden restart was not turned into stop and start.");
	chk_gc_read_abort: assert property (cmdIn.valid && !cmdRefused && gcRead
		|=> abortFlag_r && cmdAborted_r && !cmdAccepted_r)
		else $error("Read after general call did not abort.");
	chk_target_locked: assert property (wrTarget && controllerOn_r |=> $stable(cfgTarget_r))
		else $error("Target register changed while controller was on.");
	chk_own_addr_locked: assert property (wrOwnAddr && controllerOn_r |=> $stable(ownAddr_r))
		else $error("Own address changed while controller was on.");
	chk_gc_addr_hidden: assert property (cmdAccepted_r && issueGeneralCall_r |-> cmdTargetAddr_r == 10'h000)
		else $error("Target address leaked into a general call.");
	chk_self_tx_block: assert property (cmdIn.valid && !cmdRefused && selfTx |=> !cmdAccepted_r ##0 abortFlag_r)
		else $error("Master transmit to its own slave address was accepted.");
	chk_speed_rate: assert property (cfgCtrl_r.speed == `I2CB_SPEED_STD |=> sclHalfCount_r == HALF_STD)
		else $error("Standard speed did not select the standard bit time.");
	chk_wide_master: assert property (acceptEvt |=> cmdAddrWide_r == $past(cfgCtrl_r.masterWide))
		else $error("Master addressing width not taken from control.");
	chk_special_kind: assert property (cmdAccepted_r |-> !(issueGeneralCall_r && issueStartByte_r))
		else $error("General call and start byte issued together.");
	chk_ro_zero: assert property (s_axi_arvalid && arReady_r && s_axi_araddr == ADDR_TYPE_LOW
		|=> rValid_r && rData_r == 32'h00000000)
		else $error("Component register did not read as zero.");
endmodule

/* include/i2cb_regs.svh */
`ifndef I2CB_REGS_SVH
`define I2CB_REGS_SVH

// Register indices as printed; byte address is four times (index minus block base).
`define I2CB_IDX_BASE 32'h50001400
`define I2CB_IDX_PARAM_HIGH 32'h500014F6
`define I2CB_IDX_VERSION_LOW 32'h500014F8
`define I2CB_IDX_VERSION_HIGH 32'h500014FA
`define I2CB_IDX_TYPE_LOW 32'h500014FC
`define I2CB_IDX_TYPE_HIGH 32'h500014FE
`define I2CB_IDX_CONTROL 32'h50001500
`define I2CB_IDX_TARGET 32'h50001504
`define I2CB_IDX_OWN_ADDR 32'h50001508
`define I2CB_IDX_ENABLE 32'h5000150C
`define I2CB_IDX_STATUS 32'h5000150E

`define I2CB_CTRL_RESET 7'h7D
`define I2CB_TARGET_RESET 12'h055
`define I2CB_OWN_ADDR_RESET 10'h055
`define I2CB_CTRL_MSB 6
`define I2CB_TARGET_MSB 11
`define I2CB_ADDR_MSB 9
`define I2CB_ADDR7_MSB 6
`define I2CB_EN_BIT 0
`define I2CB_STAT_ABORT_BIT 6
`define I2CB_STAT_GCMODE_BIT 8
`define I2CB_STAT_MATCH_BIT 9

`define I2CB_SPEED_STD 2'h1
`define I2CB_SPEED_FAST 2'h2
`define I2CB_WIDE_PREFIX 5'h1E
`define I2CB_BYTE_LAST_BIT 4'h7
`define I2CB_ACK_BIT 4'h8

`define I2CB_SYS_CLK_NS 10
`define I2CB_STD_BIT_NS 10000
`define I2CB_FAST_BIT_NS 2500

`define I2CB_RESP_OKAY 2'h0
`define I2CB_RESP_SLVERR 2'h2

`endif

/* include/i2cb_pkg.sv */
package i2cb_pkg;

	typedef struct packed {
		logic slaveOff;
		logic restartPermit;
		logic masterWide;
		logic slaveWide;
		logic [1:0] speed;
		logic masterOn;
	} i2cb_ctrl_t;

	typedef struct packed {
		logic special;
		logic gcSel;
		logic [9:0] addr;
	} i2cb_target_t;

	typedef struct packed {
		logic valid;
		logic read;
		logic restart;
		logic stop;
	} i2cb_cmd_t;

	typedef enum logic [1:0] {
		I2CB_SNOOP_IDLE = 2'b00,
		I2CB_SNOOP_FIRST = 2'b01,
		I2CB_SNOOP_SECOND = 2'b10,
		I2CB_SNOOP_DONE = 2'b11
	} i2cb_snoop_t;

endpackage

/* testbench/i2cb_remote_master.sv */
`timescale 1ns/1ps
// Remote bus master. Both lines are driven directly, so a released line is driven high.
module i2cb_remote_master (
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Sends one byte plus the acknowledge clock; the clock is left low inside the frame.
	task automatic xfer(input logic [7:0] b, input bit start);
		if (start) begin
			sda = 1'b0;
			#40;
		end
		for (int i = 0; i < 9; i++) begin
			scl = 1'b0;
			#20;
			sda = (i == 8) ? 1'b1 : b[7 - i];
			#20;
			scl = 1'b1;
			#40;
		end
		scl = 1'b0;
	endtask
	task automatic finish();
		#20;
		sda = 1'b0;
		#20;
		scl = 1'b1;
		#40;
		sda = 1'b1;
		#40;
	endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	localparam logic [11:0] A_CTRL = 12'h400;
	localparam logic [11:0] A_TAR = 12'h410;
	localparam logic [11:0] A_OWN = 12'h420;
	localparam logic [11:0] A_EN = 12'h430;
	localparam logic [11:0] A_STAT = 12'h438;
	logic [11:0] compAddr [5] = '{12'h3D8, 12'h3E0, 12'h3E8, 12'h3F0, 12'h3F8};
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	i2cb_pkg::i2cb_cmd_t cmdIn = '0;
	logic cmdAccepted_r, cmdAborted_r, issueRestart_r, issueStopStart_r;
	logic issueGeneralCall_r, issueStartByte_r, cmdAddrWide_r, abortFlag_r;
	logic [9:0] cmdTargetAddr_r;
	logic [15:0] sclHalfCount_r;
	logic sclIn, sdaIn, slaveMatch_r, slaveMatchRead_r;
	logic [33:0] expQ [$];
	logic [9:0] tgt, own;
	int checks = 0;
	int bad_count = 0;
	int cycles = 0;

	i2cb_mode_addr_cfg #(.ADDR_W(12)) i2cb_mode_addr_cfg_inst (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmdIn(cmdIn),
		.cmdAccepted_r(cmdAccepted_r), .cmdAborted_r(cmdAborted_r), .issueRestart_r(issueRestart_r),
		.issueStopStart_r(issueStopStart_r), .issueGeneralCall_r(issueGeneralCall_r),
		.issueStartByte_r(issueStartByte_r), .cmdAddrWide_r(cmdAddrWide_r),
		.cmdTargetAddr_r(cmdTargetAddr_r), .cfgCtrl_r(), .cfgTarget_r(), .ownAddr_r(),
		.controllerOn_r(), .abortFlag_r(abortFlag_r), .sclHalfCount_r(sclHalfCount_r),
		.sclIn(sclIn), .sdaIn(sdaIn), .slaveMatch_r(slaveMatch_r), .slaveMatchRead_r(slaveMatchRead_r)
	);
	i2cb_remote_master i2cb_remote_master_inst (.scl(sclIn), .sda(sdaIn));

	always #5 sys_clk = ~sys_clk;

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic take(input logic [33:0] g);
		if (expQ.size() == 0)
			chk(g, 34'h3FFFFFFFF);
		else
			chk(g, expQ.pop_front());
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			take({s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			take({s_axi_bresp, 32'h0});
		if (cmdAborted_r === 1'b1)
			take({27'h0, cmdAccepted_r, cmdAborted_r, 5'h0});
		else if (cmdAccepted_r === 1'b1)
			take({27'h0, 2'b10, issueRestart_r, issueStopStart_r, issueGeneralCall_r, issueStartByte_r,
				cmdAddrWide_r});
	end

	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] resp);
		bit ad;
		bit wd;
		ad = 1'b0;
		wd = 1'b0;
		expQ.push_back({resp, 32'h0});
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {16'($urandom()), d};
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge sys_clk);
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge sys_clk);
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
		expQ.push_back({resp, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic cmd(input logic rdCmd, input logic rs, input logic st, input logic [6:0] sig);
		expQ.push_back({27'h0, sig});
		cmdIn <= {1'b1, rdCmd, rs, st};
		@(posedge sys_clk);
		cmdIn <= '0;
		repeat (2) @(posedge sys_clk);
	endtask

	// Target may only change while the controller is off.
	task automatic tar(input logic [1:0] mode);
		wr(A_EN, 16'h0, 2'h0);
		wr(A_TAR, {4'h0, mode, tgt}, 2'h0);
		wr(A_EN, 16'h1, 2'h0);
	endtask

	task automatic probe(input logic wide, input logic [7:0] b, input logic m);
		if (wide)
			i2cb_remote_master_inst.xfer({5'h1E, own[9:8], 1'b0}, 1'b1);
		i2cb_remote_master_inst.xfer(b, !wide);
		repeat (8) @(posedge sys_clk);
		chk(34'(slaveMatch_r), 34'(m));
		chk(34'(slaveMatchRead_r), 34'(wide ? 1'b0 : b[0]));
		i2cb_remote_master_inst.finish();
		@(posedge sys_clk);
	endtask

	initial begin
		void'($urandom(15));
		tgt = 10'($urandom());
		own = 10'($urandom());
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(A_CTRL, 32'h7D, 2'h0);
		rd(A_TAR, 32'h55, 2'h0);
		rd(A_OWN, 32'h55, 2'h0);
		chk(34'(sclHalfCount_r), 34'd125);
		foreach (compAddr[i]) begin
			wr(compAddr[i], 16'hFFFF, 2'h0);
			rd(compAddr[i], 32'h0, 2'h0);
		end
		wr(12'h100, 16'h1234, 2'h2);
		rd(12'h100, 32'h0, 2'h2);
		cmd(1'b0, 1'b0, 1'b1, 7'b0100000);
		chk(34'(abortFlag_r), 34'h0);
		wr(A_TAR, {6'h0, tgt}, 2'h0);
		wr(A_OWN, {6'h0, own}, 2'h0);
		wr(A_EN, 16'h1, 2'h0);
		rd(A_EN, 32'h1, 2'h0);
		wr(A_TAR, {6'h0, ~tgt}, 2'h0);
		wr(A_OWN, {6'h0, ~own}, 2'h0);
		rd(A_TAR, {22'h0, tgt}, 2'h0);
		rd(A_OWN, {22'h0, own}, 2'h0);
		cmd(1'b0, 1'b0, 1'b0, 7'b1000001);
		chk(34'(cmdTargetAddr_r), 34'(tgt));
		cmd(1'b1, 1'b0, 1'b1, 7'b1010001);
		wr(A_CTRL, 16'h4D, 2'h0);
		rd(A_CTRL, 32'h4D, 2'h0);
		cmd(1'b0, 1'b1, 1'b1, 7'b1001000);
		tar(2'b10);
		cmd(1'b0, 1'b0, 1'b0, 7'b1000100);
		cmd(1'b1, 1'b0, 1'b1, 7'b0100000);
		chk(34'(abortFlag_r), 34'h1);
		rd(A_STAT, 32'h141, 2'h0);
		wr(A_STAT, 16'h40, 2'h0);
		chk(34'(abortFlag_r), 34'h0);
		cmd(1'b0, 1'b0, 1'b1, 7'b1000100);
		tar(2'b11);
		cmd(1'b0, 1'b0, 1'b1, 7'b1000010);
		tar(2'b01);
		cmd(1'b0, 1'b0, 1'b1, 7'b1000000);
		wr(A_CTRL, 16'h7C, 2'h0);
		cmd(1'b0, 1'b0, 1'b1, 7'b0100000);
		wr(A_CTRL, 16'h22, 2'h0);
		chk(34'(sclHalfCount_r), 34'd500);
		probe(1'b0, {own[6:0], 1'b0}, 1'b1);
		probe(1'b0, {~own[6:0], 1'b1}, 1'b0);
		wr(A_CTRL, 16'h2A, 2'h0);
		probe(1'b1, own[7:0], 1'b1);
		wr(A_CTRL, 16'h63, 2'h0);
		probe(1'b0, {own[6:0], 1'b0}, 1'b0);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(A_CTRL, 32'h7D, 2'h0);
		rd(A_STAT, 32'h0, 2'h0);
		chk(34'(expQ.size()), 34'h0);
		test_done();
	end
endmodule
